// File: design/mcu_reset_controller.sv
// Reset source combiner with stretched internal reset and Wishbone registers
// ==========================================================================
// Functional notes
// - During reset I/O registers take initial values; fetch starts at vector.
// - Any active source resets the I/O ports at once, without a clock.
// - After all sources go inactive, a fuse-selected count stretches reset.
// - Exactly five causes: supply, pin, watchdog, under-voltage, scan.
// - Watchdog expiry resets only while the watchdog is enabled.
// - Under-voltage resets only when its detector is enabled.
// - Scan reset bit at one holds reset; releases when it returns to zero.
// - Supply rising past threshold starts the stretch counter.
// - Supply falling below threshold reasserts reset at once.
// - Watchdog gives a one-cycle pulse; counting starts at its trailing edge.
// - Scan, watchdog, under-voltage, pin flags: set by cause, cleared by POR or 0.
// - Supply-rise flag, bit zero, set by power-on, cleared by writing 0 or by RESET.
`include "rst_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mcu_reset_controller import rst_pkg::*; #(
  parameter int CNT_W = `RC_CNT_W,
  parameter int TOUT_SHORT_CYC = `RC_TOUT_SHORT_US * `RC_CLK_MHZ,
  parameter int TOUT_LONG_CYC = `RC_TOUT_LONG_US * `RC_CLK_MHZ
) (
  input wire logic CLK,                       // System clock, 25 MHz
  input wire logic RESET,                     // Synchronous reset, high
  input wire logic SUPPLY_OK,                 // Supply above power-on level
  input wire logic RESET_PIN_N,               // External reset pin, low
  input wire logic WDT_ENABLE,                // Watchdog enabled
  input wire logic WDT_TIMEOUT,               // Watchdog period expired
  input wire logic UNDERVOLTAGE_DETECTOR_EN,  // Under-voltage detector on
  input wire logic UNDERVOLTAGE_LOW,          // Supply below brown-out level
  input wire logic SCAN_RESET_BIT,            // Scan reset register bit
  input wire logic [3:0] CLOCK_SELECT_FUSES,  // Delay selection fuses
  input wire logic WB_CYC_I,                  // Wishbone cycle
  input wire logic WB_STB_I,                  // Wishbone strobe
  input wire logic WB_WE_I,                   // Wishbone write enable
  input wire logic [7:0] WB_ADR_I,            // Wishbone byte address
  input wire logic [31:0] WB_DAT_I,           // Wishbone write data
  input wire logic [3:0] WB_SEL_I,            // Wishbone byte selects
  output logic [31:0] WB_DAT_O,               // Wishbone read data
  output logic WB_ACK_O,                      // Wishbone acknowledge
  output logic IRQ,                           // Interrupt, level high
  output logic CORE_RESET,                    // Stretched internal reset
  output logic IO_RESET,                      // I/O port reset
  output logic FETCH_FROM_VECTOR              // Pulse: fetch at reset vector
);

  // ========================================================================
  // Elaboration checks
  initial begin
    if (CNT_W < 2 || CNT_W > 31) begin
      $error("CNT_W out of range");
    end
    if (TOUT_SHORT_CYC < 1 || TOUT_LONG_CYC < 1 ||
        TOUT_SHORT_CYC >= (1 << CNT_W) || TOUT_LONG_CYC >= (1 << CNT_W)) begin
      $error("Stretch counts do not fit the counter");
    end
  end

  // ========================================================================
  // Asynchronous I/O reset path
  // Raw pins set the flop directly, so a pulse with no clock still reaches
  // the ports; release waits for the clocked stretched reset.
  logic io_async_src;
  logic io_reset_r;
  logic core_reset_r;

  assign io_async_src = !SUPPLY_OK || !RESET_PIN_N || SCAN_RESET_BIT ||
                        (UNDERVOLTAGE_DETECTOR_EN && UNDERVOLTAGE_LOW) ||
                        (WDT_ENABLE && WDT_TIMEOUT);

  always_ff @(posedge CLK or posedge io_async_src) begin
    if (io_async_src) begin
      io_reset_r <= 1'b1;
    end else if (RESET) begin
      io_reset_r <= 1'b1;
    end else begin
      io_reset_r <= core_reset_r;
    end
  end
  assign IO_RESET = io_reset_r;

  // ========================================================================
  // Input synchronisers
  localparam int NS = 7;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync_a_r;
  logic [NS-1:0] sync_b_r;

  assign raw_in = {UNDERVOLTAGE_DETECTOR_EN, WDT_ENABLE, SCAN_RESET_BIT,
                   WDT_TIMEOUT, UNDERVOLTAGE_LOW, !RESET_PIN_N, !SUPPLY_OK};

  always_ff @(posedge CLK) begin
    sync_a_r <= raw_in;
    sync_b_r <= sync_a_r;
  end

  logic supply_low_s;
  logic pin_low_s;
  logic uv_low_s;
  logic wdt_to_s;
  logic scan_s;
  logic wdt_en_s;
  logic uv_en_s;
  assign supply_low_s = sync_b_r[0];
  assign pin_low_s = sync_b_r[1];
  assign uv_low_s = sync_b_r[2];
  assign wdt_to_s = sync_b_r[3];
  assign scan_s = sync_b_r[4];
  assign wdt_en_s = sync_b_r[5];
  assign uv_en_s = sync_b_r[6];

  // ========================================================================
  // Source combination
  logic wdt_prev_r;
  logic wdt_pulse;
  logic [`RC_NUM_SRC-1:0] src;
  logic any_src;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wdt_prev_r <= 1'b0;
    end else begin
      wdt_prev_r <= wdt_to_s;
    end
  end

  // Only the rising edge counts, so a long time-out level still gives one
  // reset cycle and the stretch begins right after it
  assign wdt_pulse = wdt_to_s && !wdt_prev_r && wdt_en_s;

  always_comb begin
    src = '0;
    src[`RC_BIT_SUPPLY] = supply_low_s;
    src[`RC_BIT_PIN] = pin_low_s;
    src[`RC_BIT_UV] = uv_en_s && uv_low_s;
    src[`RC_BIT_WDT] = wdt_pulse;
    src[`RC_BIT_SCAN] = scan_s;
  end
  assign any_src = |src;

  // ========================================================================
  // Stretch counter and sequencer
  logic [CNT_W-1:0] target;
  logic stretch_done;

  assign target = CLOCK_SELECT_FUSES[`RC_FUSE_LONG_BIT] ?
                  CNT_W'(TOUT_LONG_CYC) : CNT_W'(TOUT_SHORT_CYC);

  rst_delay_counter #(
    .CNT_W(CNT_W)
  ) u_delay (
    .clk(CLK),
    .rst(RESET),
    .restart(any_src),
    .target(target),
    .done(stretch_done)
  );

  rst_state_e state_r;
  rst_state_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_HOLD: begin
        if (!any_src) begin
          state_nxt = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        if (any_src) begin
          state_nxt = ST_HOLD;
        end else if (stretch_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          state_nxt = ST_HOLD;
        end
      end
      default: state_nxt = ST_HOLD;
    endcase
  end

  logic fetch_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= ST_HOLD;
      core_reset_r <= 1'b1;
      fetch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      core_reset_r <= (state_nxt != ST_RUN);
      fetch_r <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
    end
  end
  assign CORE_RESET = core_reset_r;
  assign FETCH_FROM_VECTOR = fetch_r;

  // ========================================================================
  // Wishbone slave
  logic req;
  logic wr_cause;
  logic wr_status;
  logic wr_mask;
  logic ack_r;
  logic [31:0] dat_r;
  logic [`RC_NUM_SRC-1:0] cause_r;
  logic [`RC_NUM_SRC-1:0] irq_status_r;
  logic [`RC_NUM_SRC-1:0] irq_mask_r;
  logic [`RC_NUM_SRC-1:0] src_prev_r;
  logic [`RC_NUM_SRC-1:0] src_rise;
  logic irq_r;

  assign req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_cause = req && WB_WE_I && WB_SEL_I[0] &&
                    (WB_ADR_I == `RC_ADDR_CAUSE);
  assign wr_status = req && WB_WE_I && WB_SEL_I[0] &&
                     (WB_ADR_I == `RC_ADDR_IRQ_STATUS);
  assign wr_mask = req && WB_WE_I && WB_SEL_I[0] &&
                   (WB_ADR_I == `RC_ADDR_IRQ_MASK);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      dat_r <= 32'h0000_0000;
      if (req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          `RC_ADDR_CAUSE: dat_r <= {27'h0, cause_r};
          `RC_ADDR_IRQ_STATUS: dat_r <= {27'h0, irq_status_r};
          `RC_ADDR_IRQ_MASK: dat_r <= {27'h0, irq_mask_r};
          `RC_ADDR_LIVE: dat_r <= {26'h0, core_reset_r, src};
          default: dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // ========================================================================
  // Cause flags: a cause in the same cycle as a zero write keeps its flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cause_r <= `RC_FLAGS_RESET;
    end else if (src[`RC_BIT_SUPPLY]) begin
      cause_r <= '0;
      cause_r[`RC_BIT_SUPPLY] <= 1'b1;
    end else begin
      cause_r <= (wr_cause ? (cause_r & WB_DAT_I[`RC_NUM_SRC-1:0]) : cause_r)
                 | src;
    end
  end

  // ========================================================================
  // Interrupts: rising source edges, write one to clear, set wins
  assign src_rise = src & ~src_prev_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_prev_r <= '0;
      irq_status_r <= '0;
      irq_mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      src_prev_r <= src;
      irq_status_r <= (wr_status ?
                       (irq_status_r & ~WB_DAT_I[`RC_NUM_SRC-1:0]) :
                       irq_status_r) | src_rise;
      if (wr_mask) begin
        irq_mask_r <= WB_DAT_I[`RC_NUM_SRC-1:0];
      end
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end
  assign IRQ = irq_r;

endmodule : mcu_reset_controller
`default_nettype wire

// File: design/rst_consts.svh
// Register offsets, field positions and timing figures of the reset controller
`ifndef RST_CONSTS_SVH
`define RST_CONSTS_SVH

// ==========================================================================
// Register map (byte addresses, one 32-bit word each)
`define RC_ADDR_CAUSE 8'h00
`define RC_ADDR_IRQ_STATUS 8'h04
`define RC_ADDR_IRQ_MASK 8'h08
`define RC_ADDR_LIVE 8'h0C

// ==========================================================================
// Bit positions shared by the cause flags and the interrupt registers
`define RC_BIT_SUPPLY 0
`define RC_BIT_PIN 1
`define RC_BIT_UV 2
`define RC_BIT_WDT 3
`define RC_BIT_SCAN 4
`define RC_NUM_SRC 5
`define RC_FLAGS_RESET 5'h00

// Live register: source levels in bits 4..0, stretched reset in bit 5
`define RC_BIT_LIVE_CORE 5

// ==========================================================================
// Stretch delay, times in microseconds, selected by clock_select_fuses bit
`define RC_FUSE_LONG_BIT 0
`define RC_CLK_MHZ 25
`define RC_TOUT_SHORT_US 100
`define RC_TOUT_LONG_US 4000
`define RC_CNT_W 20

`endif

// File: design/rst_delay_counter.sv
// Stretch counter: restarts from zero and reports when the target is reached
`timescale 1ns/1ps
`default_nettype none
module rst_delay_counter #(
  parameter int CNT_W = 20
) (
  input wire logic clk,                  // System clock
  input wire logic rst,                  // Synchronous reset, active high
  input wire logic restart,              // Hold counter at zero
  input wire logic [CNT_W-1:0] target,   // Cycles to count
  output logic done                      // Target reached
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_r <= '0;
    end else if (cnt_r != target) begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_r == target) && !restart;
endmodule : rst_delay_counter
`default_nettype wire

// File: design/rst_pkg.sv
// Types shared by the reset controller design
package rst_pkg;
  // Gray sequence hold -> stretch -> run
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN = 2'b11
  } rst_state_e;
endpackage : rst_pkg

// File: testbench/mcu_reset_controller_tb.sv
// Self-checking testbench of the reset controller
`include "rst_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mcu_reset_controller_tb;
  localparam int SHORT = 5;
  localparam int LONG = 20;
  localparam logic [6:0] IDLE = 7'h60;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  wire logic SUPPLY_OK, RESET_PIN_N, WDT_ENABLE, WDT_TIMEOUT;
  wire logic UNDERVOLTAGE_DETECTOR_EN, UNDERVOLTAGE_LOW, SCAN_RESET_BIT;
  logic [3:0] CLOCK_SELECT_FUSES = 4'h0;
  logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [3:0] WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_O, rd;
  logic WB_ACK_O, IRQ, CORE_RESET, IO_RESET, FETCH_FROM_VECTOR;
  int n_errors = 0;
  int cmp_count = 0;
  int n_short, n_long, n;
  logic [6:0] vec[5] = '{7'h68, 7'h78, 7'h62, 7'h66, 7'h61};
  logic [31:0] cause[5] = '{32'h00, 32'h08, 32'h00, 32'h04, 32'h10};
  rst_source_model u_src (.clk(CLK), .supply_ok(SUPPLY_OK),
    .pin_n(RESET_PIN_N), .wdt_en(WDT_ENABLE), .wdt_to(WDT_TIMEOUT),
    .uv_en(UNDERVOLTAGE_DETECTOR_EN), .uv_low(UNDERVOLTAGE_LOW),
    .scan_bit(SCAN_RESET_BIT));
  mcu_reset_controller #(.TOUT_SHORT_CYC(SHORT), .TOUT_LONG_CYC(LONG)) u_dut (.*);
  always #20 CLK = ~CLK;
  // ======
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 20);
    rd = WB_DAT_O;
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'b000;
    if (k >= 20) n_errors++;
    @(posedge CLK);
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // Cycles from the call until the core reset is seen low
  task automatic stretch(output int c);
    c = 0;
    do begin
      @(posedge CLK);
      c++;
    end while (CORE_RESET !== 1'b0 && c < 500);
  endtask : stretch
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // ======
  // Tests
  initial begin
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    u_src.set_lvl(IDLE);
    stretch(n);
    rdc(`RC_ADDR_CAUSE, 32'h01);
    rdc(`RC_ADDR_LIVE, 32'h00);
    rdc(8'h10, 32'h00);
    $display("test power_on done");
    wb(1'b1, `RC_ADDR_IRQ_STATUS, 32'h1F);
    u_src.pin_pulse(4);
    stretch(n_short);
    rdc(`RC_ADDR_CAUSE, 32'h03);
    chk({31'h0, IRQ}, 32'h0);
    wb(1'b1, `RC_ADDR_IRQ_MASK, 32'h02);
    chk({31'h0, IRQ}, 32'h1);
    wb(1'b1, `RC_ADDR_IRQ_STATUS, 32'h02);
    chk({31'h0, IRQ}, 32'h0);
    wb(1'b1, `RC_ADDR_CAUSE, 32'h00);
    rdc(`RC_ADDR_CAUSE, 32'h00);
    $display("test pin done");
    CLOCK_SELECT_FUSES <= 4'h1;
    u_src.pin_pulse(4);
    stretch(n_long);
    chk(32'(n_long - n_short), 32'(LONG - SHORT));
    CLOCK_SELECT_FUSES <= 4'h0;
    u_src.pin_pulse(4);
    repeat (3) @(posedge CLK);
    u_src.pin_pulse(4);
    stretch(n);
    chk(32'(n), 32'(n_short));
    $display("test stretch done");
    u_src.set_lvl(7'h20);
    #1;
    chk({31'h0, IO_RESET}, 32'h1);
    repeat (4) @(posedge CLK);
    u_src.set_lvl(IDLE);
    stretch(n);
    rdc(`RC_ADDR_CAUSE, 32'h01);
    wb(1'b1, `RC_ADDR_CAUSE, 32'h00);
    $display("test supply_drop done");
    for (int i = 0; i < 5; i++) begin
      u_src.set_lvl(vec[i]);
      repeat (4) @(posedge CLK);
      u_src.set_lvl(IDLE);
      stretch(n);
      chk(32'(n > 1), 32'(cause[i] != 0));
      rdc(`RC_ADDR_CAUSE, cause[i]);
      wb(1'b1, `RC_ADDR_CAUSE, 32'h00);
    end
    $display("test sources done");
    end_sim();
  end
  initial begin
    #(40 * 4000);
    n_errors++;
    end_sim();
  end
endmodule : mcu_reset_controller_tb
bind mcu_reset_controller rst_ctrl_checker #(.TOUT_SHORT_CYC(TOUT_SHORT_CYC))
  u_chk (.*);
`default_nettype wire

// File: testbench/rst_ctrl_checker.sv
// Port assertions for the reset controller
`timescale 1ns/1ps
`default_nettype none
module rst_ctrl_checker #(
  parameter int TOUT_SHORT_CYC = 5
) (
  input wire logic CLK, // Clock
  input wire logic RESET, // Reset
  input wire logic SUPPLY_OK, // Supply good
  input wire logic RESET_PIN_N, // Pin
  input wire logic UNDERVOLTAGE_DETECTOR_EN, // Detector on
  input wire logic UNDERVOLTAGE_LOW, // Under-voltage
  input wire logic SCAN_RESET_BIT, // Scan bit
  input wire logic IRQ, // Interrupt
  input wire logic CORE_RESET, // Core reset
  input wire logic IO_RESET, // Port reset
  input wire logic FETCH_FROM_VECTOR // Fetch pulse
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  int hi_cnt_r;
  // ======
  // Length of the current core reset, cleared by the block reset
  always_ff @(posedge CLK) begin
    if (RESET) hi_cnt_r <= 0;
    else hi_cnt_r <= CORE_RESET ? hi_cnt_r + 1 : 0;
  end
  // ======
  // Properties
  property p_io_core; CORE_RESET |-> IO_RESET; endproperty
  a_io_core: assert property (p_io_core) else $error("io reset low");
  property p_fetch;
    FETCH_FROM_VECTOR |-> $fell(CORE_RESET) ##1 !FETCH_FROM_VECTOR;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pulse bad");
  property p_io_fall; $fell(IO_RESET) |-> $past(FETCH_FROM_VECTOR); endproperty
  a_io_fall: assert property (p_io_fall) else $error("io early");
  property p_pin_io; !RESET_PIN_N |-> IO_RESET; endproperty
  a_pin_io: assert property (p_pin_io) else $error("pin no io");
  property p_supply_io; !SUPPLY_OK |-> IO_RESET; endproperty
  a_supply_io: assert property (p_supply_io) else $error("por no io");
  property p_uv_io;
    UNDERVOLTAGE_DETECTOR_EN && UNDERVOLTAGE_LOW |-> IO_RESET;
  endproperty
  a_uv_io: assert property (p_uv_io) else $error("uv no io");
  property p_scan_core; SCAN_RESET_BIT [*5] |-> CORE_RESET; endproperty
  a_scan_core: assert property (p_scan_core) else $error("scan");
  property p_pin_core; !RESET_PIN_N [*5] |-> CORE_RESET; endproperty
  a_pin_core: assert property (p_pin_core) else $error("pin core");
  property p_stretch; $fell(CORE_RESET) |-> hi_cnt_r >= TOUT_SHORT_CYC;
  endproperty
  a_stretch: assert property (p_stretch) else $error("short");
  c_release: cover property ($fell(CORE_RESET));
  c_irq: cover property ($rose(IRQ));
  c_scan: cover property (SCAN_RESET_BIT ##1 CORE_RESET);
endmodule : rst_ctrl_checker
`default_nettype wire

// File: testbench/rst_source_model.sv
// Model of the supply monitors, reset pin and other reset sources
`timescale 1ns/1ps
`default_nettype none
module rst_source_model (
  input wire logic clk, // Clock
  output logic supply_ok, // Supply good
  output logic pin_n, // Reset pin
  output logic wdt_en, // Watchdog on
  output logic wdt_to, // Watchdog expiry
  output logic uv_en, // Detector on
  output logic uv_low, // Under-voltage
  output logic scan_bit // Scan bit
);
  // Power comes up low, pin released
  initial {supply_ok, pin_n, wdt_en, wdt_to, uv_en, uv_low, scan_bit} = 7'h20;
  task automatic set_lvl(input logic [6:0] v);
    @(posedge clk);
    {supply_ok, pin_n, wdt_en, wdt_to, uv_en, uv_low, scan_bit} <= v;
  endtask : set_lvl
  // Several cycles low, far above the minimum pulse width
  task automatic pin_pulse(input int n);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    pin_n <= 1'b1;
  endtask : pin_pulse
endmodule : rst_source_model
`default_nettype wire
